// [mrss_pkg.sv]
// Constants, types and register layout of the reset source sequencer.
// Assumes one clock, ref_clk at 125 MHz, and an asynchronous active-high reset.
package mrss_pkg;

  // Register offsets.
  localparam logic [15:0] MRSS_OPTION_SELECT_WORD_OFF  = 16'hffff;
  localparam logic [15:0] MRSS_PROCESSOR_MODE_REG0_OFF = 16'h0004;
  localparam logic [15:0] MRSS_PROCESSOR_MODE_REG1_OFF = 16'h0005;
  localparam logic [15:0] MRSS_MONITOR0_CONTROL_OFF    = 16'h0038;
  localparam logic [15:0] MRSS_DETECTOR_CONTROL2_OFF   = 16'h0032;
  localparam logic [15:0] MRSS_RESET_STATUS_OFF        = 16'h0010;

  // Field positions.
  localparam int MRSS_SW_RESET_BIT       = 3;
  localparam int MRSS_WDT_RESET_SEL_BIT  = 2;
  localparam int MRSS_MON0_ENABLE_BIT    = 0;
  localparam int MRSS_MON0_MODE_BIT      = 6;
  localparam int MRSS_DET0_ENABLE_BIT    = 5;
  localparam int MRSS_MON0_DISABLE_BIT   = 5;

  // Values after reset and after erase.
  localparam logic [7:0] MRSS_OPTION_ERASED  = 8'hff;
  localparam logic [7:0] MRSS_REG_RESET      = 8'h00;
  localparam logic [7:0] MRSS_PORT_DIR_INPUT = 8'h00;

  // Release timing counts in low-speed oscillator cycles; the sequence length counts ref_clk cycles.
  localparam logic [5:0] MRSS_LOCO_RELEASE_COUNT = 6'h20;
  localparam logic [2:0] MRSS_CPU_CLK_DIV_MAX    = 3'h7;
  localparam logic [1:0] MRSS_SEQ_LEN            = 2'h3;

  // Reset cause codes, shown in the status register.
  typedef enum logic [2:0] {
    MRSS_CAUSE_NONE,
    MRSS_CAUSE_PIN,
    MRSS_CAUSE_POWER,
    MRSS_CAUSE_MON0,
    MRSS_CAUSE_MON1,
    MRSS_CAUSE_MON2,
    MRSS_CAUSE_WDT,
    MRSS_CAUSE_SW
  } mrss_cause_e;

  // Register bus request.
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } mrss_bus_s;

endpackage

// [mrss_sequencer.sv]
// Reset source sequencer: gathers reset sources and drives the internal reset.
// Assumes the bus master keeps one-cycle strobes; pins and detector levels are
// asynchronous and pass two flip-flops before use.
`timescale 1ns/1ps
module mrss_sequencer
  import mrss_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        reset_n_pin,
  input  wire logic        supply_above_level_0,
  input  wire logic        supply_above_level_1,
  input  wire logic        supply_above_level_2,
  input  wire logic        monitor1_reset_enable,
  input  wire logic        monitor2_reset_enable,
  input  wire logic        watchdog_underflow,
  input  wire logic        loco_tick,
  input  wire logic        ram_write_busy,
  input  wire logic [7:0]  option_word_image,
  input  wire mrss_bus_s   bus,
  output logic      [7:0]  rdata,
  output logic             internal_reset,
  output logic             cpu_fetch_vector,
  output logic             cpu_clk_loco_div8,
  output logic             cpu_clk_en,
  output logic             ports_force_input,
  output logic      [7:0]  port_dir_override,
  output logic             ram_contents_undefined
);

  // Two-flop synchronisers for asynchronous inputs.
  // Clearing to zero makes the pin read low, so reset stands until the pin is seen high.
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else begin
      sync1_q <= {loco_tick, supply_above_level_2, supply_above_level_1,
                  supply_above_level_0, reset_n_pin};
      sync2_q <= sync1_q;
    end
  end

  logic pin_low;
  logic lvl0_ok;
  logic lvl1_ok;
  logic lvl2_ok;
  logic tick_s;
  assign pin_low = ~sync2_q[0];
  assign lvl0_ok = sync2_q[1];
  assign lvl1_ok = sync2_q[2];
  assign lvl2_ok = sync2_q[3];
  assign tick_s  = sync2_q[4];

  // Edge of the low-speed oscillator tick after synchronising.
  // The previous value resets low, the oscillator's idle level, so no false edge follows.
  logic tick_prev_q;
  logic tick_rise;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tick_prev_q <= 1'b0;
    end else begin
      tick_prev_q <= tick_s;
    end
  end
  assign tick_rise = tick_s & ~tick_prev_q;

  // Option word is a read-only image of flash; erased flash reads all ones.
  // Sampling it once keeps a later flash write from acting until the reset input is next raised.
  logic [7:0] option_q;
  logic       opt_loaded_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      option_q     <= MRSS_OPTION_ERASED;
      opt_loaded_q <= 1'b0;
    end else if (!opt_loaded_q) begin
      option_q     <= option_word_image;
      opt_loaded_q <= 1'b1;
    end
  end

  // Software registers, cleared by full resets except where noted.
  logic [7:0] pm0_q;
  logic [7:0] pm1_q;
  logic [7:0] mon0_ctl_q;
  logic [7:0] det_ctl2_q;
  logic       sw_req;
  logic       full_rst;
  logic       hw_rst_q;

  // The request acts in the cycle of the write; the reset that it starts
  // clears the mode register again, so the bit never reads back as set.
  assign sw_req = bus.wr && bus.addr == MRSS_PROCESSOR_MODE_REG0_OFF
                  && bus.wdata[MRSS_SW_RESET_BIT];

  // Mode registers are cleared by every internal reset.
  // Writes are refused while reset stands, so software cannot race the sequence.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pm0_q <= MRSS_REG_RESET;
      pm1_q <= MRSS_REG_RESET;
    end else if (internal_reset) begin
      pm0_q <= MRSS_REG_RESET;
      pm1_q <= MRSS_REG_RESET;
    end else if (bus.wr) begin
      if (bus.addr == MRSS_PROCESSOR_MODE_REG0_OFF) begin
        pm0_q <= bus.wdata;
      end
      if (bus.addr == MRSS_PROCESSOR_MODE_REG1_OFF) begin
        pm1_q <= bus.wdata;
      end
    end
  end

  // Monitor 0 control survives software, watchdog and monitor 1/2 resets; a
  // hardware or power reset loads its enables from the option word.
  // The enables follow the option word for as long as the hardware marker stands.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mon0_ctl_q <= MRSS_REG_RESET;
      det_ctl2_q <= MRSS_REG_RESET;
    end else if (hw_rst_q) begin
      mon0_ctl_q[MRSS_MON0_ENABLE_BIT] <= ~option_q[MRSS_MON0_DISABLE_BIT];
      mon0_ctl_q[MRSS_MON0_MODE_BIT]   <= ~option_q[MRSS_MON0_DISABLE_BIT];
      det_ctl2_q[MRSS_DET0_ENABLE_BIT] <= ~option_q[MRSS_MON0_DISABLE_BIT];
    end else if (bus.wr && !internal_reset) begin
      if (bus.addr == MRSS_MONITOR0_CONTROL_OFF) begin
        mon0_ctl_q <= bus.wdata;
      end
      if (bus.addr == MRSS_DETECTOR_CONTROL2_OFF) begin
        det_ctl2_q <= bus.wdata;
      end
    end
  end

  // Monitor 0 resets only with its enable, its reset mode and detector 0 all set.
  logic mon0_armed;
  assign mon0_armed = mon0_ctl_q[MRSS_MON0_ENABLE_BIT] & mon0_ctl_q[MRSS_MON0_MODE_BIT]
                      & det_ctl2_q[MRSS_DET0_ENABLE_BIT];

  // Latch a power-up in progress until level 0 is first reached.
  // Until then the power-on path holds reset whatever the enables say.
  logic por_pend_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      por_pend_q <= 1'b1;
    end else if (lvl0_ok) begin
      por_pend_q <= 1'b0;
    end
  end

  // Active source levels.
  // Monitor 1 and 2 enables come from logic on this clock and need no synchroniser.
  logic src_pin;
  logic src_lvl0;
  logic src_lvl1;
  logic src_lvl2;
  logic src_wdt;
  assign src_pin  = pin_low;
  assign src_lvl0 = ~lvl0_ok & (mon0_armed | por_pend_q);
  assign src_lvl1 = ~lvl1_ok & monitor1_reset_enable;
  assign src_lvl2 = ~lvl2_ok & monitor2_reset_enable;
  assign src_wdt  = watchdog_underflow & pm1_q[MRSS_WDT_RESET_SEL_BIT];

  // Hardware-reset marker: set while the pin or power-up holds reset.
  // It comes out of reset high, since power-up counts as a hardware reset.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      hw_rst_q <= 1'b1;
    end else begin
      hw_rst_q <= src_pin | por_pend_q;
    end
  end

  // Sequencer states.
  // Hold waits for every source to end; count and sequence then time the release.
  typedef enum logic [1:0] {
    MRSS_RUN,
    MRSS_HOLD,
    MRSS_COUNT,
    MRSS_SEQ
  } mrss_state_e;

  mrss_state_e state_q;
  logic [5:0]  loco_cnt_q;
  logic [1:0]  seq_cnt_q;
  logic        any_src;
  logic        lvl0_timed_q;
  assign any_src = src_pin | src_lvl0 | src_lvl1 | src_lvl2 | src_wdt | sw_req;
  assign full_rst = any_src;

  // Main sequence: hold, count 32 oscillator cycles if level 0 ended, then
  // a short reset sequence before release.
  // A source that returns during the count or the sequence goes back to hold.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q      <= MRSS_HOLD;
      loco_cnt_q   <= 6'h00;
      seq_cnt_q    <= 2'h0;
      lvl0_timed_q <= 1'b1;
    end else begin
      case (state_q)
        MRSS_RUN: begin
          if (full_rst) begin
            state_q      <= MRSS_HOLD;
            lvl0_timed_q <= src_lvl0;
          end
        end
        MRSS_HOLD: begin
          // Both counts restart here, so a sequence cut short never shortens the next.
          loco_cnt_q <= 6'h00;
          seq_cnt_q  <= 2'h0;
          if (src_lvl0) begin
            lvl0_timed_q <= 1'b1;
          end
          if (!any_src) begin
            state_q <= lvl0_timed_q ? MRSS_COUNT : MRSS_SEQ;
          end
        end
        MRSS_COUNT: begin
          if (any_src) begin
            state_q <= MRSS_HOLD;
          end else if (loco_cnt_q == MRSS_LOCO_RELEASE_COUNT) begin
            state_q <= MRSS_SEQ;
          end else if (tick_rise) begin
            loco_cnt_q <= loco_cnt_q + 6'h01;
          end
        end
        MRSS_SEQ: begin
          if (any_src) begin
            state_q <= MRSS_HOLD;
          end else if (seq_cnt_q == MRSS_SEQ_LEN) begin
            state_q      <= MRSS_RUN;
            seq_cnt_q    <= 2'h0;
            lvl0_timed_q <= 1'b0;
          end else begin
            seq_cnt_q <= seq_cnt_q + 2'h1;
          end
        end
        default: state_q <= MRSS_HOLD;
      endcase
    end
  end

  // Last cause, kept for software.
  // The pin takes priority, then the levels in order, then the watchdog.
  mrss_cause_e cause_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cause_q <= MRSS_CAUSE_POWER;
    end else if (state_q == MRSS_RUN && full_rst) begin
      if (src_pin) cause_q <= MRSS_CAUSE_PIN;
      else if (src_lvl0) cause_q <= MRSS_CAUSE_MON0;
      else if (src_lvl1) cause_q <= MRSS_CAUSE_MON1;
      else if (src_lvl2) cause_q <= MRSS_CAUSE_MON2;
      else if (src_wdt) cause_q <= MRSS_CAUSE_WDT;
      else cause_q <= MRSS_CAUSE_SW;
    end
  end

  // Reset is asserted combinationally on any source so no edge is missed.
  // The state alone would let a one-cycle source pass before hold is entered.
  assign internal_reset = (state_q != MRSS_RUN) | full_rst;

  // Vector fetch pulse when the sequence hands over to the CPU.
  // Registered, it stands for exactly the first cycle out of reset.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cpu_fetch_vector <= 1'b0;
    end else begin
      cpu_fetch_vector <= state_q == MRSS_SEQ && seq_cnt_q == MRSS_SEQ_LEN
                          && !any_src;
    end
  end

  // CPU clock falls back to oscillator divided by 8 on every reset.
  // The divider restarts at zero, so the first enable after release comes 8 ticks late.
  logic [2:0] div_q;
  logic       div8_sel_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      div_q      <= 3'h0;
      div8_sel_q <= 1'b1;
    end else begin
      if (internal_reset) begin
        div8_sel_q <= 1'b1;
        div_q      <= 3'h0;
      end else if (tick_rise) begin
        div_q <= div_q + 3'h1;
      end
    end
  end
  assign cpu_clk_loco_div8 = div8_sel_q;
  assign cpu_clk_en = tick_rise && div_q == MRSS_CPU_CLK_DIV_MAX && !internal_reset;

  // Ports are inputs while the pin is low and during any internal reset.
  // The direction override stays at all inputs; only the force flag moves.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ports_force_input <= 1'b1;
      port_dir_override <= MRSS_PORT_DIR_INPUT;
    end else begin
      ports_force_input <= src_pin | internal_reset;
      port_dir_override <= MRSS_PORT_DIR_INPUT;
    end
  end

  // RAM is never cleared; a reset hitting a write flags the contents undefined.
  // A status write clears the flag, but not while reset stands; the set wins.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ram_contents_undefined <= 1'b0;
    end else if (full_rst && ram_write_busy) begin
      ram_contents_undefined <= 1'b1;
    end else if (bus.wr && !internal_reset && bus.addr == MRSS_RESET_STATUS_OFF) begin
      ram_contents_undefined <= 1'b0;
    end
  end

  // Read port: data in the cycle after the strobe; unmapped reads zero.
  // Zero outside the answer cycle keeps the shared read bus quiet.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        MRSS_OPTION_SELECT_WORD_OFF:  rdata <= option_q;
        MRSS_PROCESSOR_MODE_REG0_OFF: rdata <= pm0_q;
        MRSS_PROCESSOR_MODE_REG1_OFF: rdata <= pm1_q;
        MRSS_MONITOR0_CONTROL_OFF:    rdata <= mon0_ctl_q;
        MRSS_DETECTOR_CONTROL2_OFF:   rdata <= det_ctl2_q;
        MRSS_RESET_STATUS_OFF:        rdata <= {ram_contents_undefined, 4'h0, cause_q};
        default:                      rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// [mrss_sequencer_sva.sv]
// Concurrent assertions on the ports of the reset source sequencer.
// Assumes one clock, ref_clk, and the asynchronous active-high reset.
`timescale 1ns/1ps
module mrss_sequencer_chk
  import mrss_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       reset,
  input wire logic       reset_n_pin,
  input wire logic       supply_above_level_1,
  input wire logic       supply_above_level_2,
  input wire logic       monitor1_reset_enable,
  input wire logic       monitor2_reset_enable,
  input wire logic       watchdog_underflow,
  input wire logic       ram_write_busy,
  input wire logic [7:0] option_word_image,
  input wire mrss_bus_s  bus,
  input wire logic [7:0] rdata,
  input wire logic       internal_reset,
  input wire logic       cpu_fetch_vector,
  input wire logic       cpu_clk_loco_div8,
  input wire logic       cpu_clk_en,
  input wire logic       ports_force_input,
  input wire logic [7:0] port_dir_override,
  input wire logic       ram_contents_undefined
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic wsel_q;

  // Shadow of the watchdog reset selection; cleared by any internal reset to stay cautious.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      wsel_q <= 1'b0;
    else if (internal_reset)
      wsel_q <= 1'b0;
    else if (bus.wr && bus.addr == MRSS_PROCESSOR_MODE_REG1_OFF)
      wsel_q <= bus.wdata[MRSS_WDT_RESET_SEL_BIT];
  end

  AST_PIN_HOLD: assert property ((!reset_n_pin) [*4] |-> internal_reset)
    else $error("Reset pin held low without internal reset.");
  AST_PORTS_IN: assert property ((!reset_n_pin) [*5] |->
    ports_force_input && port_dir_override == MRSS_PORT_DIR_INPUT)
    else $error("Ports not forced to input while reset pin low.");
  AST_SW_RESET: assert property (bus.wr && bus.addr == MRSS_PROCESSOR_MODE_REG0_OFF
    && bus.wdata[MRSS_SW_RESET_BIT] && !$past(internal_reset) |=> internal_reset [*5])
    else $error("Software request did not hold reset.");
  AST_WDT: assert property (watchdog_underflow && wsel_q |-> internal_reset)
    else $error("Selected watchdog underflow gave no reset.");
  AST_LVL1: assert property ((!supply_above_level_1 && monitor1_reset_enable) [*4]
    |-> internal_reset)
    else $error("Low supply at level 1 gave no reset.");
  AST_LVL2: assert property ((!supply_above_level_2 && monitor2_reset_enable) [*4]
    |-> internal_reset)
    else $error("Low supply at level 2 gave no reset.");
  AST_FETCH: assert property ($fell(internal_reset) |-> ##[0:1] cpu_fetch_vector)
    else $error("No vector fetch at reset release.");
  AST_FETCH_ONE: assert property (cpu_fetch_vector |-> !internal_reset ##1 !cpu_fetch_vector)
    else $error("Vector fetch not a single cycle outside reset.");
  AST_HOLD_MIN: assert property ($fell(internal_reset) |-> $past(internal_reset, 4))
    else $error("Internal reset released without its sequence.");
  AST_CLK_SEL: assert property (!internal_reset |-> cpu_clk_loco_div8)
    else $error("CPU clock not divided oscillator after reset.");
  AST_CLK_EN: assert property (cpu_clk_en |-> !internal_reset)
    else $error("CPU clock enable pulsed during reset.");
  AST_RAM: assert property (ram_write_busy && $rose(internal_reset)
    |-> ##[0:3] ram_contents_undefined)
    else $error("Reset during RAM write not flagged.");
  AST_OPT_RD: assert property (bus.rd && bus.addr == MRSS_OPTION_SELECT_WORD_OFF
    |=> rdata == option_word_image)
    else $error("Option word read back wrong.");
endmodule

bind mrss_sequencer mrss_sequencer_chk chk_u (
  .ref_clk, .reset, .reset_n_pin, .supply_above_level_1, .supply_above_level_2,
  .monitor1_reset_enable, .monitor2_reset_enable, .watchdog_underflow, .ram_write_busy,
  .option_word_image, .bus, .rdata, .internal_reset, .cpu_fetch_vector, .cpu_clk_loco_div8,
  .cpu_clk_en, .ports_force_input, .port_dir_override, .ram_contents_undefined
);

// [mrss_far_model.sv]
// Far side: external reset driver, supply detectors and low-speed oscillator.
// Assumes the bench calls its tasks by hierarchical name; delays are in ns.
`timescale 1ns/1ps
module mrss_far_model #(
  parameter int SETTLE_NS    = 1000,
  parameter int LOCO_HALF_NS = 21
) (
  output logic       reset_n_pin,
  output logic [2:0] supply_above,
  output logic       loco_tick
);
  // Power-up holds the pin low through the supply rise, settle time and 10 us.
  initial begin
    reset_n_pin = 1'b0;
    supply_above = 3'h0;
    loco_tick = 1'b0;
    #200;
    supply_above = 3'h7;
    #(SETTLE_NS + 10000);
    reset_n_pin = 1'b1;
  end

  // The oscillator runs free, unrelated in phase to ref_clk.
  always #(LOCO_HALF_NS) loco_tick = ~loco_tick;

  // Pin reset with a stable supply keeps the pin low for 10 us.
  task automatic pin_pulse();
    reset_n_pin = 1'b0;
    #10000;
    reset_n_pin = 1'b1;
  endtask

  // Moves one detector output; high means supply at or above its level.
  task automatic set_lvl(input int i, input logic v);
    supply_above[i] = v;
  endtask
endmodule

// [testbench.sv]
// Self-checking bench for the reset source sequencer.
// Assumes the far-side model drives the pin, detector levels and oscillator.
`timescale 1ns/1ps
module testbench;
  import mrss_pkg::*;
  localparam logic [7:0] OPT = 8'hdf;
  logic       ref_clk;
  logic       reset;
  logic       pin_n;
  logic [2:0] lvl;
  logic       loco;
  logic       mon1_en;
  logic       mon2_en;
  logic       wdog;
  logic       ram_busy;
  mrss_bus_s  bus;
  logic [7:0] rdata;
  logic [7:0] dir;
  logic       irst;
  logic       fetch;
  logic       div8;
  logic       clk_en;
  logic       force_in;
  logic       ram_undef;
  int         fails = 0;
  int         n_checks = 0;
  int         n;
  int         lo[3] = '{160, 4, 4};
  int         hi[3] = '{190, 12, 12};

  mrss_far_model far_u (.reset_n_pin(pin_n), .supply_above(lvl), .loco_tick(loco));

  mrss_sequencer dut_u (
    .ref_clk(ref_clk), .reset(reset), .reset_n_pin(pin_n),
    .supply_above_level_0(lvl[0]), .supply_above_level_1(lvl[1]),
    .supply_above_level_2(lvl[2]), .monitor1_reset_enable(mon1_en),
    .monitor2_reset_enable(mon2_en), .watchdog_underflow(wdog), .loco_tick(loco),
    .ram_write_busy(ram_busy), .option_word_image(OPT), .bus(bus), .rdata(rdata),
    .internal_reset(irst), .cpu_fetch_vector(fetch), .cpu_clk_loco_div8(div8),
    .cpu_clk_en(clk_en), .ports_force_input(force_in), .port_dir_override(dir),
    .ram_contents_undefined(ram_undef)
  );

  // Clock of 8 ns period.
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus <= '0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus <= '0;
    #1 check({24'h0, rdata}, {24'h0, exp});
  endtask

  // Counts cycles until internal reset drops, bounded.
  task automatic wait_rel(output int cyc);
    cyc = 0;
    while (irst !== 1'b0 && cyc < 4000) begin
      @(posedge ref_clk);
      #1;
      cyc++;
    end
    check(irst, 0);
    check(fetch, 1);
    check(div8, 1);
  endtask

  task automatic wdog_pulse(input logic exp);
    @(posedge ref_clk);
    wdog <= 1'b1;
    @(posedge ref_clk);
    wdog <= 1'b0;
    #1 check(irst, exp);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence of scenarios.
  initial begin
    reset = 1'b1;
    bus = '0;
    mon1_en = 1'b0;
    mon2_en = 1'b0;
    wdog = 1'b0;
    ram_busy = 1'b0;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    wait_rel(n);
    check(n > 1250, 1);
    rd(MRSS_OPTION_SELECT_WORD_OFF, OPT);
    wr(MRSS_OPTION_SELECT_WORD_OFF, 8'h00);
    rd(MRSS_OPTION_SELECT_WORD_OFF, OPT);
    rd(16'h0fff, 8'h00);
    wr(MRSS_MONITOR0_CONTROL_OFF, 8'h41);
    wr(MRSS_DETECTOR_CONTROL2_OFF, 8'h20);
    for (int i = 0; i < 3; i++) begin
      @(posedge ref_clk);
      mon1_en <= (i == 1);
      mon2_en <= (i == 2);
      @(posedge ref_clk);
      far_u.set_lvl(i, 1'b0);
      repeat (4) @(posedge ref_clk);
      #1 check(irst, 1);
      far_u.set_lvl(i, 1'b1);
      wait_rel(n);
      check(n >= lo[i] && n <= hi[i], 1);
    end
    @(posedge ref_clk);
    mon1_en <= 1'b0;
    mon2_en <= 1'b0;
    @(posedge ref_clk);
    far_u.set_lvl(1, 1'b0);
    repeat (4) @(posedge ref_clk);
    #1 check(irst, 0);
    far_u.set_lvl(1, 1'b1);
    wr(MRSS_PROCESSOR_MODE_REG0_OFF, 8'h08);
    #1 check(irst, 1);
    wait_rel(n);
    check(n >= 4 && n <= 8, 1);
    n = 0;
    repeat (100) begin
      @(posedge ref_clk);
      #1;
      if (clk_en === 1'b1) n++;
    end
    check(n, 2);
    check(ram_undef, 0);
    rd(MRSS_MONITOR0_CONTROL_OFF, 8'h41);
    wdog_pulse(1'b0);
    wr(MRSS_PROCESSOR_MODE_REG1_OFF, 8'h04);
    wdog_pulse(1'b1);
    wait_rel(n);
    @(posedge ref_clk);
    ram_busy <= 1'b1;
    fork
      far_u.pin_pulse();
      begin
        repeat (20) @(posedge ref_clk);
        #1 check(force_in, 1);
        check(dir, 8'h00);
      end
    join
    wait_rel(n);
    check(n >= 4 && n <= 12, 1);
    check(ram_undef, 1);
    @(posedge ref_clk);
    ram_busy <= 1'b0;
    rd(MRSS_RESET_STATUS_OFF, 8'h81);
    wr(MRSS_RESET_STATUS_OFF, 8'h00);
    rd(MRSS_RESET_STATUS_OFF, 8'h01);
    finish_test();
  end

  // Cuts a hang short well beyond the expected run of about 26 us.
  initial begin
    #400000;
    fails++;
    finish_test();
  end
endmodule
